// [hw/gsc_gesture_sequence_control.sv]
// Gesture sequence controller: emitter sequencing, result capture, flags and interrupt
`timescale 1ns/1ps
`default_nettype none
module gsc_gesture_sequence_control (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Host configuration
	input wire logic gesture_enable,
	input wire logic forced_measure_mode,
	input wire logic [1:0] emitter_select,
	input wire logic interrupt_enable,
	input wire logic trigger_write,
	input wire logic flag_read,
	// Analog front end
	input wire logic convert_done,
	input wire logic [15:0] convert_result,
	// Emitter drive and conversion request
	output logic [2:0] infrared_emitter,
	output logic convert_start,
	// Results and status
	output logic [15:0] proximity_result_one,
	output logic [15:0] proximity_channel_two,
	output logic [15:0] proximity_result_three,
	output logic [1:0] interrupt_flags,
	output logic forced_measure_trigger,
	output logic busy,
	output logic int_n
);
	// ----------------------------------------
	// Internal state
	// ----------------------------------------
	gsc_pkg::gsc_state_t state;
	gsc_pkg::gsc_state_t next_state;
	logic [1:0] slot;
	logic [1:0] next_slot;
	logic gesture_run;
	logic [15:0] result_bank [gsc_pkg::EMITTER_COUNT];
	logic [2:0] emitter_mask;

	// ----------------------------------------
	// State decode
	// ----------------------------------------
	wire idle = (state == gsc_pkg::GSC_IDLE);
	wire firing = (state == gsc_pkg::GSC_FIRE);
	wire waiting = (state == gsc_pkg::GSC_WAIT);
	wire storing = (state == gsc_pkg::GSC_STORE);

	// ----------------------------------------
	// Launch and sequencing decode
	// ----------------------------------------
	// Free-running mode measures continually; forced mode only on trigger
	wire launch = idle && (forced_measure_trigger || !forced_measure_mode);
	wire launch_gesture = launch && gesture_enable && forced_measure_mode;
	wire last_slot = !gesture_run || (slot == gsc_pkg::EMITTER_THREE);
	wire store_now = waiting && convert_done;
	wire done_gesture = store_now && gesture_run && last_slot;
	wire done_single = store_now && !gesture_run;
	wire [1:0] start_slot = launch_gesture ? gsc_pkg::EMITTER_ONE : emitter_select;
	wire advance_slot = storing && !last_slot;

	// ----------------------------------------
	// Flag and interrupt decode
	// ----------------------------------------
	wire [1:0] next_flags_set = {done_single, done_gesture};
	// Flags that survive this cycle's read-clear
	wire [1:0] flags_kept = flag_read ? gsc_pkg::FLAG_RESET : interrupt_flags;
	// Set wins over a simultaneous read-clear
	wire [1:0] next_flags = flags_kept | next_flags_set;
	// A flag cleared by this read counts as zero, so a new set still pulls low
	wire rising_flag = |(next_flags_set & ~flags_kept);
	wire pull_int = rising_flag && interrupt_enable;
	wire release_int = flag_read && !pull_int;

	// ----------------------------------------
	// Slot selection
	// ----------------------------------------
	always_comb begin
		next_slot = slot;
		if (launch) begin
			next_slot = start_slot;
		end else if (advance_slot) begin
			next_slot = slot + 2'h1;
		end
	end

	// ----------------------------------------
	// Per-emitter drive mask and result bank
	// ----------------------------------------
	// An invalid selection lights nothing and stores nothing
	genvar gi;
	generate
		for (gi = 0; gi < gsc_pkg::EMITTER_COUNT; gi++) begin : g_emitter
			wire hit = (slot == 2'(gi));
			assign emitter_mask[gi] = hit;
			always_ff @(posedge clk_sys) begin
				if (!rstn) begin
					result_bank[gi] <= gsc_pkg::RESULT_RESET;
				end else if (store_now && hit) begin
					result_bank[gi] <= convert_result;
				end
			end
		end
	endgenerate

	assign proximity_result_one = result_bank[0];
	assign proximity_channel_two = result_bank[1];
	assign proximity_result_three = result_bank[2];

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			gsc_pkg::GSC_IDLE: begin
				if (launch) begin
					next_state = gsc_pkg::GSC_FIRE;
				end
			end
			gsc_pkg::GSC_FIRE: next_state = gsc_pkg::GSC_WAIT;
			gsc_pkg::GSC_WAIT: begin
				if (convert_done) begin
					next_state = gsc_pkg::GSC_STORE;
				end
			end
			gsc_pkg::GSC_STORE: begin
				next_state = last_slot ? gsc_pkg::GSC_IDLE : gsc_pkg::GSC_FIRE;
			end
			default: next_state = gsc_pkg::GSC_IDLE;
		endcase
	end

	// ----------------------------------------
	// Sequencer state
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			state <= gsc_pkg::GSC_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			slot <= gsc_pkg::EMITTER_ONE;
		end else begin
			slot <= next_slot;
		end
	end

	// The run kind is latched at launch so a mid-run enable change cannot mix modes
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			gesture_run <= 1'b0;
		end else if (launch) begin
			gesture_run <= launch_gesture;
		end
	end

	// ----------------------------------------
	// Conversion request and busy status
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			convert_start <= 1'b0;
		end else begin
			convert_start <= firing;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			busy <= 1'b0;
		end else begin
			busy <= (next_state != gsc_pkg::GSC_IDLE);
		end
	end

	// ----------------------------------------
	// Emitter drive
	// ----------------------------------------
	// Emitter stays lit from fire until its result is taken
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			infrared_emitter <= 3'h0;
		end else if (firing) begin
			infrared_emitter <= emitter_mask;
		end else if (store_now) begin
			infrared_emitter <= 3'h0;
		end
	end

	// ----------------------------------------
	// Trigger bit: set by host, cleared on start
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			forced_measure_trigger <= 1'b0;
		end else if (trigger_write) begin
			forced_measure_trigger <= 1'b1;
		end else if (launch) begin
			forced_measure_trigger <= 1'b0;
		end
	end

	// ----------------------------------------
	// Interrupt flags
	// ----------------------------------------
	// Flags are sticky until the host reads them
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			interrupt_flags <= gsc_pkg::FLAG_RESET;
		end else begin
			interrupt_flags <= next_flags;
		end
	end

	// ----------------------------------------
	// Interrupt pin
	// ----------------------------------------
	// A new rise in the read cycle keeps the pin low, so no event is lost
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			int_n <= 1'b1;
		end else if (pull_int) begin
			int_n <= 1'b0;
		end else if (release_int) begin
			int_n <= 1'b1;
		end
	end
endmodule // gsc_gesture_sequence_control
`default_nettype wire

// [shared/gsc_pkg.sv]
// Constants and types shared by the gesture sequence controller
`default_nettype none
package gsc_pkg;
	localparam int unsigned EMITTER_COUNT = 3;
	localparam int unsigned RESULT_WIDTH = 16;
	localparam logic [1:0] EMITTER_ONE = 2'h0;
	localparam logic [1:0] EMITTER_TWO = 2'h1;
	localparam logic [1:0] EMITTER_THREE = 2'h2;
	// Index of the gesture ready bit inside the flag word
	localparam int unsigned FLAG_GESTURE_READY = 0;
	localparam int unsigned FLAG_SINGLE_READY = 1;
	localparam int unsigned FLAG_WIDTH = 2;
	localparam logic [RESULT_WIDTH-1:0] RESULT_RESET = 16'h0000;
	localparam logic [FLAG_WIDTH-1:0] FLAG_RESET = 2'h0;
	// Gray-coded sequence: idle -> fire -> wait -> store -> idle, or store -> fire for the next gesture slot
	typedef enum logic [1:0] {
		GSC_IDLE = 2'b00,
		GSC_FIRE = 2'b01,
		GSC_WAIT = 2'b11,
		GSC_STORE = 2'b10
	} gsc_state_t;
endpackage
`default_nettype wire

// [bench/gsc_checker.sv]
// Assertions on the gesture sequence controller ports
`timescale 1ns/1ps
`default_nettype none
module gsc_checker(input wire logic clk_sys, input wire logic rstn,
	input wire logic gesture_enable, input wire logic forced_measure_mode,
	input wire logic interrupt_enable, input wire logic flag_read, input wire logic convert_start,
	input wire logic [2:0] infrared_emitter, input wire logic [1:0] interrupt_flags,
	input wire logic forced_measure_trigger, input wire logic busy, input wire logic int_n);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	sequence s_armed; forced_measure_mode && forced_measure_trigger && !busy; endsequence
	sequence s_quiet; forced_measure_mode && !forced_measure_trigger && !busy; endsequence
	property p_one; |infrared_emitter |-> $onehot(infrared_emitter); endproperty
	a_one: assert property (p_one) else $error("emitters");
	property p_lit; convert_start |-> $onehot(infrared_emitter); endproperty
	a_lit: assert property (p_lit) else $error("lit");
	property p_pulse; convert_start |=> !convert_start; endproperty
	a_pulse: assert property (p_pulse) else $error("pulse");
	property p_arm; s_armed |=> busy && !forced_measure_trigger; endproperty
	a_arm: assert property (p_arm) else $error("arm");
	property p_quiet; s_quiet |=> !busy; endproperty
	a_quiet: assert property (p_quiet) else $error("quiet");
	property p_ready; $fell(busy) && gesture_enable && forced_measure_mode |-> interrupt_flags[0];
	endproperty
	a_ready: assert property (p_ready) else $error("ready");
	property p_int; $rose(interrupt_flags[0]) && interrupt_enable |-> !int_n; endproperty
	a_int: assert property (p_int) else $error("int");
	property p_clear; flag_read ##0 s_quiet |=> interrupt_flags == 2'h0 && int_n; endproperty
	a_clear: assert property (p_clear) else $error("clear");
	property p_order; $fell(infrared_emitter[0]) && busy && gesture_enable |-> ##[1:3] infrared_emitter[1];
	endproperty
	a_order: assert property (p_order) else $error("order");
endmodule // gsc_checker
bind gsc_gesture_sequence_control gsc_checker chk_u(.clk_sys, .rstn, .gesture_enable,
	.forced_measure_mode, .interrupt_enable, .flag_read, .convert_start, .infrared_emitter,
	.interrupt_flags, .forced_measure_trigger, .busy, .int_n);
`default_nettype wire

// [bench/gsc_afe_model.sv]
// Front end model: answers each conversion request after a random delay
`timescale 1ns/1ps
`default_nettype none
module gsc_afe_model(input wire logic clk_sys, input wire logic convert_start,
	output logic convert_done, output logic [15:0] convert_result);
	initial begin
		convert_done = 0;
		convert_result = 16'h0;
		forever begin
			@(posedge clk_sys);
			if (convert_start) begin
				repeat ($urandom_range(3)) @(posedge clk_sys);
				convert_done <= 1;
				convert_result <= 16'($urandom);
				@(posedge clk_sys);
				convert_done <= 0;
				// Stale data is inverted so a late capture cannot match
				convert_result <= ~convert_result;
			end
		end
	end
endmodule // gsc_afe_model
`default_nettype wire

// [bench/gsc_gesture_sequence_control_tb.sv]
// Testbench for the gesture sequence controller
`timescale 1ns/1ps
`default_nettype none
module gsc_gesture_sequence_control_tb;
	logic clk_sys = 0, rstn = 0, gesture_enable = 0, forced_measure_mode = 1, interrupt_enable = 0;
	logic trigger_write = 0, flag_read = 0, convert_done, convert_start, busy, int_n, forced_measure_trigger;
	logic [1:0] emitter_select = 2'h0, interrupt_flags;
	logic [2:0] infrared_emitter;
	logic [15:0] convert_result, r1, r2, r3;
	logic [15:0] q[$];
	logic [2:0] e[$];
	int error_cnt = 0, compares = 0, i, n;
	initial forever #2.5 clk_sys = ~clk_sys;
	gsc_gesture_sequence_control dut_u(.clk_sys, .rstn, .gesture_enable, .forced_measure_mode,
		.emitter_select, .interrupt_enable, .trigger_write, .flag_read, .convert_done,
		.convert_result, .infrared_emitter, .convert_start, .proximity_result_one(r1),
		.proximity_channel_two(r2), .proximity_result_three(r3), .interrupt_flags,
		.forced_measure_trigger, .busy, .int_n);
	gsc_afe_model afe_u(.clk_sys, .convert_start, .convert_done, .convert_result);
	always @(posedge clk_sys) begin
		if (convert_done) q.push_back(convert_result);
		if (convert_start) e.push_back(infrared_emitter);
	end
	function logic [2:0] lit(int k); return 3'h1 << k; endfunction
	task chk(string s, logic [15:0] seen, logic [15:0] ex);
		compares++;
		if (seen !== ex) begin
			error_cnt++;
			$display("BAD %s exp %h seen %h", s, ex, seen);
		end
	endtask
	task summarize;
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		void'($urandom(47));
		repeat (20) @(posedge clk_sys);
		rstn <= 1;
		repeat (20) @(negedge clk_sys);
		chk("standby", 16'(e.size()), 16'h0);
		chk("rst_busy", 16'(busy), 16'h0);
		chk("rst_int", 16'(int_n), 16'h1);
		for (i = 0; i < 8; i++) begin
			@(posedge clk_sys);
			interrupt_enable <= 1'($urandom_range(1));
			gesture_enable <= i < 5;
			emitter_select <= 2'($urandom_range(2));
			q = {};
			e = {};
			@(posedge clk_sys) trigger_write <= 1;
			@(posedge clk_sys) trigger_write <= 0;
			for (n = 0; n < 200 && interrupt_flags[i < 5 ? 0 : 1] !== 1'b1; n++) @(negedge clk_sys);
			chk("int", 16'(int_n), 16'(!interrupt_enable));
			if (i < 5) begin
				for (n = 0; n < 3; n++) chk("emitter", 16'(e[n]), 16'(lit(n)));
				chk("one", r1, q[0]);
				chk("two", r2, q[1]);
				chk("three", r3, q[2]);
			end else begin
				chk("select", 16'(e[0]), 16'(lit(emitter_select)));
				chk("chan", emitter_select == 0 ? r1 : emitter_select == 1 ? r2 : r3, q[0]);
				chk("gready", 16'(interrupt_flags[0]), 16'h0);
			end
			@(posedge clk_sys) flag_read <= 1;
			@(posedge clk_sys) flag_read <= 0;
			repeat (9) @(negedge clk_sys);
			chk("flags", 16'(interrupt_flags), 16'h0);
			chk("intclr", 16'(int_n), 16'h1);
			chk("count", 16'(e.size()), i < 5 ? 16'h3 : 16'h1);
		end
		@(posedge clk_sys);
		gesture_enable <= 1;
		emitter_select <= 2'h1;
		forced_measure_mode <= 0;
		q = {};
		e = {};
		for (n = 0; n < 200 && interrupt_flags[1] !== 1'b1; n++) @(negedge clk_sys);
		chk("cont_emit", 16'(e[0]), 16'(lit(1)));
		chk("cont_chan", r2, q[0]);
		chk("cont_gready", 16'(interrupt_flags[0]), 16'h0);
		@(posedge clk_sys);
		forced_measure_mode <= 1;
		gesture_enable <= 0;
		for (n = 0; n < 200 && busy !== 1'b0; n++) @(negedge clk_sys);
		@(posedge clk_sys) flag_read <= 1;
		@(posedge clk_sys) flag_read <= 0;
		repeat (4) @(negedge clk_sys);
		chk("cont_stop", 16'(busy), 16'h0);
		chk("cont_flags", 16'(interrupt_flags), 16'h0);
		summarize;
	end
	initial begin
		#50us;
		error_cnt++;
		summarize;
	end
endmodule // gsc_gesture_sequence_control_tb
`default_nettype wire
